// File: core/i2c_seq_pkg.sv
// Package: register map, field positions, reset values and carriers for the I2C master sequencer
package i2c_seq_pkg;

  // ************************************************************
  // Register offsets and banks
  // ************************************************************
  localparam logic [7:0] OFF_CORE_INT     = 8'h07;
  localparam logic [7:0] OFF_FLAGS_TWO    = 8'h10;
  localparam logic [7:0] OFF_ENABLES_TWO  = 8'h11;
  localparam logic [7:0] OFF_ADDR_RELOAD  = 8'h10;
  localparam logic [7:0] OFF_CONTROL_ONE  = 8'h11;
  localparam logic [7:0] OFF_CONTROL_TWO  = 8'h12;
  localparam logic [7:0] OFF_STATUS       = 8'h13;
  localparam logic [7:0] OFF_SHIFT_BUF    = 8'h14;
  localparam logic [7:0] BANKED_BASE      = 8'h10;
  localparam logic [3:0] BANK_FLAGS       = 4'h4;
  localparam logic [3:0] BANK_SERIAL      = 4'h6;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_PERIPH_FLAG   = 7;
  localparam int BIT_PERIPH_ENABLE = 3;
  localparam int BIT_SERIAL_IRQ    = 7;
  localparam int BIT_BUS_COLL      = 6;
  localparam int BIT_WRITE_COLL    = 7;
  localparam int BIT_PORT_ENABLE   = 5;
  localparam int BIT_STOP_SEQ      = 2;
  localparam int BIT_START_SEQ     = 0;
  localparam int BIT_STOP_DET      = 4;
  localparam int BIT_START_DET     = 3;
  localparam int BIT_BUF_FULL      = 0;
  localparam int RELOAD_MSB        = 6;

  // ************************************************************
  // Reset values and sizes
  // ************************************************************
  localparam logic [7:0] RST_REG    = 8'h00;
  localparam int         FIFO_WIDTH = 8;
  localparam int         FIFO_DEPTH = 32;
  localparam logic [3:0] LAST_BIT   = 4'h8;

  // Event toggles from link domain to register domain
  localparam int EV_START_DET  = 0;
  localparam int EV_STOP_DET   = 1;
  localparam int EV_COLLISION  = 2;
  localparam int EV_START_DONE = 3;
  localparam int EV_STOP_DONE  = 4;
  localparam int EV_BYTE_DONE  = 5;
  localparam int EV_BYTE_ACK   = 6;
  localparam int EV_COUNT      = 7;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] bank;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic       start;
    logic       stop;
    logic [6:0] reload;
  } link_cmd_t;

endpackage

// File: core/byte_fifo.sv
// Synchronous FIFO with valid/ready handshake on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Full and empty come straight from the fill count
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

  // Storage has no reset; only the pointers and the fill count need one
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      fill   <= (AW+1)'(fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

endmodule
`default_nettype wire

// File: core/i2c_master_start_stop_control.sv
// I2C master START/STOP sequencer with register file and link-clock bus engine
`timescale 1ns/1ps
`default_nettype none
module i2c_master_start_stop_control (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  link_clk,
  input  wire i2c_seq_pkg::cpu_req_t cpu_req,
  output logic [7:0]                 cpu_rdata,
  input  wire logic                  cpu_sleep,
  output logic                       periph_irq,
  output logic                       wake_req,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  input  wire logic                  scl_in,
  output logic                       scl_out,
  output logic                       scl_oe_n
);
  import i2c_seq_pkg::*;

  // Register hit decode, shared by every read and write path
  function automatic logic reg_hit(input cpu_req_t r, input logic [7:0] off,
                                   input logic [3:0] bank);
    reg_hit = (r.addr == off) & ((off < BANKED_BASE) | (r.bank == bank));
  endfunction

  // ************************************************************
  // Register domain state
  // ************************************************************
  logic [7:0]          core_interrupt_status;
  logic [7:0]          peripheral_flags_two;
  logic [7:0]          peripheral_enables_two;
  logic [7:0]          slave_address_reload;
  logic [7:0]          serial_control_one;
  logic [7:0]          serial_control_two;
  logic                stop_detected;
  logic                start_detected;
  logic [7:0]          serial_shift_buffer;
  link_cmd_t           cmd_q;
  logic                cmd_tgl;
  logic [7:0]          byte_q;
  logic                byte_tgl;
  logic [EV_COUNT-1:0] ev_s1;
  logic [EV_COUNT-1:0] ev_s2;
  logic [EV_COUNT-1:0] ev_s3;

  // Link domain state, declared here for the crossings
  logic [EV_COUNT-1:0] ev_tgl;
  logic [7:0]          rx_hold;

  // ************************************************************
  // Register decode
  // ************************************************************
  wire hit_core  = reg_hit(cpu_req, OFF_CORE_INT, BANK_FLAGS);
  wire hit_flags = reg_hit(cpu_req, OFF_FLAGS_TWO, BANK_FLAGS);
  wire hit_ens   = reg_hit(cpu_req, OFF_ENABLES_TWO, BANK_FLAGS);
  wire hit_rld   = reg_hit(cpu_req, OFF_ADDR_RELOAD, BANK_SERIAL);
  wire hit_con1  = reg_hit(cpu_req, OFF_CONTROL_ONE, BANK_SERIAL);
  wire hit_con2  = reg_hit(cpu_req, OFF_CONTROL_TWO, BANK_SERIAL);
  wire hit_stat  = reg_hit(cpu_req, OFF_STATUS, BANK_SERIAL);
  wire hit_buf   = reg_hit(cpu_req, OFF_SHIFT_BUF, BANK_SERIAL);
  wire wr_core   = cpu_req.wr & hit_core;
  wire wr_flags  = cpu_req.wr & hit_flags;
  wire wr_con1   = cpu_req.wr & hit_con1;
  wire wr_con2   = cpu_req.wr & hit_con2;
  wire wr_buf    = cpu_req.wr & hit_buf;

  // Event pulses recovered from the link toggles
  wire [EV_COUNT-1:0] ev_pulse = ev_s2 ^ ev_s3;
  wire port_en     = serial_control_one[BIT_PORT_ENABLE];
  wire stop_active = serial_control_two[BIT_STOP_SEQ];

  // Byte handshake to the link: one byte outstanding at a time
  wire tx_busy = byte_tgl ^ ev_s2[EV_BYTE_ACK];

  // Buffer write refused while STOP runs or queue is full
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       buf_accept = wr_buf & ~stop_active & fifo_in_ready;
  wire       write_collision_flag_set   = wr_buf & ~buf_accept;
  wire       fifo_pop   = fifo_out_valid & ~tx_busy;

  // Commands start only on a written 0-to-1 edge of the enables
  wire cmd_start = wr_con2 & port_en & cpu_req.wdata[BIT_START_SEQ]
                   & ~serial_control_two[BIT_START_SEQ];
  wire cmd_stop  = wr_con2 & port_en & cpu_req.wdata[BIT_STOP_SEQ]
                   & ~stop_active;

  // Completion and match events raise the serial flag
  wire addr_match = ev_pulse[EV_BYTE_DONE]
                    & (rx_hold[7:1] == slave_address_reload[7:1]);
  wire irq_set    = ev_pulse[EV_START_DONE] | ev_pulse[EV_STOP_DONE]
                    | ev_pulse[EV_BYTE_DONE] | addr_match;
  wire coll_set   = ev_pulse[EV_COLLISION];

  // Set wins over a software clear in the same cycle
  wire [7:0] next_flags = ((wr_flags ? cpu_req.wdata : peripheral_flags_two)
                           | ({7'h00, irq_set} << BIT_SERIAL_IRQ)
                           | ({7'h00, coll_set} << BIT_BUS_COLL));
  wire [7:0] next_con1  = (wr_con1 ? cpu_req.wdata : serial_control_one)
                          | ({7'h00, write_collision_flag_set} << BIT_WRITE_COLL);

  // Hardware clears the sequence enables when the sequence ends
  wire       clr_start = ev_pulse[EV_START_DONE] | ev_pulse[EV_COLLISION];
  wire       clr_stop  = ev_pulse[EV_STOP_DONE];
  wire [7:0] con2_base = wr_con2 ? cpu_req.wdata : serial_control_two;
  wire [7:0] next_con2 = con2_base
                         & ~({7'h00, clr_start} << BIT_START_SEQ)
                         & ~({7'h00, clr_stop} << BIT_STOP_SEQ);

  // Peripheral request from any enabled sticky flag
  wire [1:0] irq_pair = {peripheral_flags_two[BIT_SERIAL_IRQ],
                         peripheral_flags_two[BIT_BUS_COLL]}
                        & {peripheral_enables_two[BIT_SERIAL_IRQ],
                           peripheral_enables_two[BIT_BUS_COLL]};
  wire       periph_any = |irq_pair;
  wire       next_wake  = cpu_sleep & peripheral_flags_two[BIT_SERIAL_IRQ]
                          & peripheral_enables_two[BIT_SERIAL_IRQ];

  // Read mux; unmapped addresses read as zero
  wire [7:0] status_word = ({7'h00, stop_detected} << BIT_STOP_DET)
                           | ({7'h00, start_detected} << BIT_START_DET)
                           | ({7'h00, fifo_out_valid} << BIT_BUF_FULL);
  wire [7:0] core_word   = (core_interrupt_status & ~(8'h01 << BIT_PERIPH_FLAG))
                           | ({7'h00, periph_any} << BIT_PERIPH_FLAG);
  wire [7:0] next_rdata  = hit_core  ? core_word :
                           hit_flags ? peripheral_flags_two :
                           hit_ens   ? peripheral_enables_two :
                           hit_rld   ? slave_address_reload :
                           hit_con1  ? serial_control_one :
                           hit_con2  ? serial_control_two :
                           hit_stat  ? status_word :
                           hit_buf   ? serial_shift_buffer : 8'h00;

  // ************************************************************
  // Register file
  // ************************************************************
  // Every register returns to its reset value, disabling the port
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      core_interrupt_status  <= RST_REG;
      peripheral_flags_two   <= RST_REG;
      peripheral_enables_two <= RST_REG;
      slave_address_reload   <= RST_REG;
      serial_control_one     <= RST_REG;
      serial_control_two     <= RST_REG;
    end else begin
      core_interrupt_status  <= wr_core ? cpu_req.wdata : core_interrupt_status;
      peripheral_flags_two   <= next_flags;
      peripheral_enables_two <= (cpu_req.wr & hit_ens) ? cpu_req.wdata
                                                       : peripheral_enables_two;
      slave_address_reload   <= (cpu_req.wr & hit_rld) ? cpu_req.wdata
                                                       : slave_address_reload;
      serial_control_one     <= next_con1;
      serial_control_two     <= next_con2;
    end
  end

  // Bus state bits follow the last condition seen on the wires
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stop_detected  <= 1'b0;
      start_detected <= 1'b0;
    end else if (ev_pulse[EV_STOP_DET]) begin
      stop_detected  <= 1'b1;
      start_detected <= 1'b0;
    end else if (ev_pulse[EV_START_DET]) begin
      stop_detected  <= 1'b0;
      start_detected <= 1'b1;
    end
  end

  // Received byte lands in the buffer only after completion
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serial_shift_buffer <= RST_REG;
    end else if (ev_pulse[EV_BYTE_DONE]) begin
      serial_shift_buffer <= rx_hold;
    end
  end

  // Outputs held in flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_rdata  <= RST_REG;
      periph_irq <= 1'b0;
      wake_req   <= 1'b0;
    end else begin
      cpu_rdata  <= cpu_req.rd ? next_rdata : cpu_rdata;
      periph_irq <= periph_any;
      wake_req   <= next_wake;
    end
  end

  // Command word is held stable until the next toggle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_q    <= '0;
      cmd_tgl  <= 1'b0;
      byte_q   <= RST_REG;
      byte_tgl <= 1'b0;
    end else begin
      if (cmd_start | cmd_stop) begin
        cmd_q   <= '{start: cmd_start, stop: cmd_stop,
                     reload: slave_address_reload[RELOAD_MSB:0]};
        cmd_tgl <= ~cmd_tgl;
      end
      if (fifo_pop) begin
        byte_q   <= fifo_out_data;
        byte_tgl <= ~byte_tgl;
      end
    end
  end

  // Link events into the register clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ev_s1 <= '0;
      ev_s2 <= '0;
      ev_s3 <= '0;
    end else begin
      ev_s1 <= ev_tgl;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) tx_fifo (
    .clk       (ref_clk),
    .rst       (rst),
    .in_data   (cpu_req.wdata),
    .in_valid  (wr_buf & ~stop_active),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (~tx_busy)
  );

  // ************************************************************
  // Link domain
  // ************************************************************
  typedef enum logic [3:0] {
    L_IDLE, L_START1, L_START2, L_HOLD, L_BIT_LO, L_BIT_HI,
    L_STOP1, L_STOP2, L_STOP3, L_STOP4, L_STOP5
  } link_state_t;

  link_state_t state;
  logic [2:0]  sync_rst;
  logic [2:0]  sync_en;
  logic [2:0]  sync_cmd;
  logic [2:0]  sync_byte;
  logic [1:0]  sda_sync;
  logic [1:0]  scl_sync;
  logic        sda_prev;
  link_cmd_t   lcmd;
  logic [7:0]  lbyte;
  logic        start_pend;
  logic        stop_pend;
  logic        byte_pend;
  logic [6:0]  cnt;
  logic [3:0]  bit_idx;
  logic [8:0]  tx_shift;
  logic [7:0]  rx_shift;

  wire link_rst = sync_rst[1] | ~sync_en[1];
  wire s_sda    = sda_sync[1];
  wire s_scl    = scl_sync[1];
  wire cmd_new  = sync_cmd[1] ^ sync_cmd[2];
  wire byte_new = sync_byte[1] ^ sync_byte[2];
  wire cnt_zero = (cnt == 7'h00);

  wire start_take = (state == L_IDLE) & start_pend;
  wire byte_take  = (state == L_HOLD) & byte_pend;
  wire stop_take  = (state == L_HOLD) & stop_pend & ~byte_pend;
  wire start_bad  = start_take & (~s_sda | ~s_scl);
  wire early_coll = (state == L_START1) & s_sda & ~s_scl;
  wire bit_end    = (state == L_BIT_HI) & s_scl & cnt_zero;

  // Event sources, each turned into a toggle for the crossing
  wire [EV_COUNT-1:0] ev_set;
  assign ev_set[EV_START_DET]  = sda_prev & ~s_sda & s_scl;
  assign ev_set[EV_STOP_DET]   = ~sda_prev & s_sda & s_scl;
  assign ev_set[EV_COLLISION]  = start_bad | early_coll;
  assign ev_set[EV_START_DONE] = (state == L_START2) & cnt_zero;
  assign ev_set[EV_STOP_DONE]  = (state == L_STOP5) & cnt_zero;
  assign ev_set[EV_BYTE_DONE]  = bit_end & (bit_idx == LAST_BIT);
  assign ev_set[EV_BYTE_ACK]   = byte_take;

  // Reset, enable, pins and toggles from outside this clock
  always_ff @(posedge link_clk) begin
    sync_rst  <= {sync_rst[1:0], rst};
    sync_en   <= {sync_en[1:0], port_en};
    sync_cmd  <= {sync_cmd[1:0], cmd_tgl};
    sync_byte <= {sync_byte[1:0], byte_tgl};
    sda_sync  <= {sda_sync[0], sda_in};
    scl_sync  <= {scl_sync[0], scl_in};
    sda_prev  <= s_sda;
  end

  // Pending requests captured from the stable command words
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lcmd       <= '0;
      lbyte      <= RST_REG;
      start_pend <= 1'b0;
      stop_pend  <= 1'b0;
      byte_pend  <= 1'b0;
      ev_tgl     <= '0;
    end else begin
      lcmd       <= cmd_new ? cmd_q : lcmd;
      lbyte      <= byte_new ? byte_q : lbyte;
      start_pend <= (start_pend & ~start_take) | (cmd_new & cmd_q.start);
      stop_pend  <= (stop_pend & ~stop_take) | (cmd_new & cmd_q.stop);
      byte_pend  <= (byte_pend & ~byte_take) | byte_new;
      ev_tgl     <= ev_tgl ^ ev_set;
    end
  end

  // Open-drain drivers always pull low when enabled
  always_ff @(posedge link_clk) begin
    sda_out <= 1'b0;
    scl_out <= 1'b0;
  end

  // Bus sequencer; reset or disable drops the transfer at once
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state    <= L_IDLE;
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      cnt      <= 7'h00;
      bit_idx  <= 4'h0;
      tx_shift <= 9'h1ff;
      rx_shift <= 8'h00;
      rx_hold  <= 8'h00;
    end else begin
      unique case (state)
        L_IDLE: begin
          sda_oe_n <= 1'b1;
          scl_oe_n <= 1'b1;
          if (start_take & ~start_bad) begin
            cnt   <= lcmd.reload;
            state <= L_START1;
          end
        end
        L_START1: begin
          if (early_coll) begin
            state <= L_IDLE;
          end else if (~s_sda | cnt_zero) begin
            sda_oe_n <= 1'b0;
            cnt      <= lcmd.reload;
            state    <= L_START2;
          end else begin
            cnt <= cnt - 7'h01;
          end
        end
        L_START2: begin
          // SCL low here is another master's START, not a collision
          if (cnt_zero) begin
            scl_oe_n <= 1'b0;
            state    <= L_HOLD;
          end else begin
            cnt <= cnt - 7'h01;
          end
        end
        L_HOLD: begin
          scl_oe_n <= 1'b0;
          if (byte_take) begin
            tx_shift <= {lbyte, 1'b1};
            sda_oe_n <= lbyte[7];
            bit_idx  <= 4'h0;
            cnt      <= lcmd.reload;
            state    <= L_BIT_LO;
          end else if (stop_take) begin
            sda_oe_n <= 1'b0;
            state    <= L_STOP1;
          end
        end
        L_BIT_LO: begin
          if (cnt_zero) begin
            scl_oe_n <= 1'b1;
            cnt      <= lcmd.reload;
            state    <= L_BIT_HI;
          end else begin
            cnt <= cnt - 7'h01;
          end
        end
        L_BIT_HI: begin
          // A slave stretching SCL stalls the count
          if (bit_end) begin
            scl_oe_n <= 1'b0;
            cnt      <= lcmd.reload;
            if (bit_idx == LAST_BIT) begin
              sda_oe_n <= 1'b1;
              state    <= L_HOLD;
            end else begin
              rx_shift <= {rx_shift[6:0], s_sda};
              rx_hold  <= (bit_idx == 4'h7) ? {rx_shift[6:0], s_sda} : rx_hold;
              tx_shift <= {tx_shift[7:0], 1'b1};
              sda_oe_n <= tx_shift[7];
              bit_idx  <= bit_idx + 4'h1;
              state    <= L_BIT_LO;
            end
          end else if (s_scl) begin
            cnt <= cnt - 7'h01;
          end
        end
        L_STOP1: begin
          if (~s_sda) begin
            cnt   <= lcmd.reload;
            state <= L_STOP2;
          end
        end
        L_STOP2: begin
          if (cnt_zero) begin
            scl_oe_n <= 1'b1;
            cnt      <= lcmd.reload;
            state    <= L_STOP3;
          end else begin
            cnt <= cnt - 7'h01;
          end
        end
        L_STOP3: begin
          if (cnt_zero) begin
            sda_oe_n <= 1'b1;
            state    <= L_STOP4;
          end else begin
            cnt <= cnt - 7'h01;
          end
        end
        L_STOP4: begin
          if (s_sda & s_scl) begin
            cnt   <= lcmd.reload;
            state <= L_STOP5;
          end
        end
        L_STOP5: begin
          if (cnt_zero) begin
            state <= L_IDLE;
          end else begin
            cnt <= cnt - 7'h01;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: test/i2c_seq_assertions.sv
// Port checker for the I2C START/STOP sequencer
`timescale 1ns/1ps
`default_nettype none
module i2c_seq_checker (
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire i2c_seq_pkg::cpu_req_t cpu_req,
  input wire logic [7:0]            cpu_rdata,
  input wire logic                  cpu_sleep,
  input wire logic                  periph_irq,
  input wire logic                  wake_req,
  input wire logic                  sda_oe_n,
  input wire logic                  scl_oe_n
);
  import i2c_seq_pkg::*;
  // ****
  // Register clock domain
  // ****
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Read of a hole in the serial bank
  wire logic unmapped_rd = cpu_req.rd && cpu_req.bank == 4'h6 && cpu_req.addr == 8'h15;
  // Cycles spent in reset; counted here, long repetitions choke the tools
  logic [3:0] rst_run = 4'h0;
  always_ff @(posedge ref_clk) begin
    rst_run <= !rst ? 4'h0 : (rst_run == 4'hf) ? rst_run : rst_run + 4'h1;
  end
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !periph_irq && !wake_req)
    else $error("irq or wake after reset");
  a_reset_pins: assert property (disable iff (1'b0) rst && rst_run >= 4'h8 |-> sda_oe_n && scl_oe_n)
    else $error("pins pulled during reset");
  a_wake_sleep: assert property (wake_req |-> $past(cpu_sleep))
    else $error("wake while awake");
  a_sleep_drop: assert property ($fell(cpu_sleep) |=> !wake_req)
    else $error("wake held after sleep end");
  a_wake_irq: assert property (wake_req |-> periph_irq)
    else $error("wake without irq");
  a_rdata_stands: assert property (!cpu_req.rd [*2] |=> $stable(cpu_rdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (unmapped_rd |-> ##2 cpu_rdata == 8'h00)
    else $error("hole read not zero");
  a_irq_cause: assert property ($rose(periph_irq) |-> !$past(rst))
    else $error("irq straight out of reset");
  c_irq: cover property ($rose(periph_irq));
  c_wake: cover property ($rose(wake_req));
  c_start: cover property ($fell(scl_oe_n));
endmodule
bind i2c_master_start_stop_control i2c_seq_checker chk (.ref_clk, .rst, .cpu_req, .cpu_rdata,
  .cpu_sleep, .periph_irq, .wake_req, .sda_oe_n, .scl_oe_n);
`default_nettype wire

// File: test/i2c_bus_model.sv
// Shared bus: pull-ups plus another master that can hold SCL low
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
  input  wire logic sda_oe_n,
  input  wire logic scl_oe_n,
  input  wire logic other_scl_low,
  output logic      sda,
  output logic      scl
);
  // Wired AND; a released line rises through its pull-up
  assign sda = sda_oe_n;
  assign scl = scl_oe_n & !other_scl_low;
endmodule
`default_nettype wire

// File: test/tb_i2c_master_start_stop_control.sv
// Self-checking bench for the I2C START/STOP sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_master_start_stop_control;
  import i2c_seq_pkg::*;
  logic       ref_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst = 1'b1;
  logic       cpu_sleep = 1'b0;
  logic       other_scl_low = 1'b0;
  cpu_req_t   req = '0;
  logic [7:0] rdata;
  logic       periph_irq, wake_req, sda, scl, sda_oe_n, scl_oe_n;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  // ****
  // Clocks, design and bus
  // ****
  initial forever #50 ref_clk = ~ref_clk;
  initial #33 forever #80 link_clk = ~link_clk;
  i2c_master_start_stop_control dut (.ref_clk, .rst, .link_clk, .cpu_req(req), .cpu_rdata(rdata),
    .cpu_sleep, .periph_irq, .wake_req, .sda_in(sda), .sda_out(), .sda_oe_n, .scl_in(scl),
    .scl_out(), .scl_oe_n);
  i2c_bus_model bus (.sda_oe_n, .scl_oe_n, .other_scl_low, .sda, .scl);
  // Bus access and compare helpers
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] b, input logic [7:0] a, d);
    @(negedge ref_clk);
    req = '{a, b, 1'b1, 1'b0, d};
    @(negedge ref_clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] b, input logic [7:0] a, e, m = 8'hff);
    @(negedge ref_clk);
    req = '{a, b, 1'b0, 1'b1, 8'h00};
    @(negedge ref_clk);
    req.rd = 1'b0;
    @(negedge ref_clk);
    chk(rdata & m, e);
  endtask
  // Bounded wait: a lost completion must not hang the run
  task automatic wait_irq;
    for (int n = 0; n < 3000 && periph_irq !== 1'b1; n++) @(negedge ref_clk);
    chk({7'h0, periph_irq}, 8'h01);
  endtask
  task automatic t_reset_values;
    logic [11:0] regs [7] = '{12'h007, 12'h410, 12'h411, 12'h610, 12'h611, 12'h612, 12'h615};
    foreach (regs[i]) rd(regs[i][11:8], regs[i][7:0], 8'h00);
  endtask
  task automatic t_start;
    wr(4'h6, 8'h10, 8'h03);
    wr(4'h6, 8'h11, 8'h20);
    wr(4'h4, 8'h11, 8'hc0);
    wr(4'h6, 8'h12, 8'h01);
    wait_irq();
    chk({6'h0, sda_oe_n, scl_oe_n}, 8'h00);
    rd(4'h4, 8'h10, 8'h80);
    rd(4'h6, 8'h12, 8'h00);
    rd(4'h6, 8'h13, 8'h08, 8'h09);
    cpu_sleep = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk({7'h0, wake_req}, 8'h01);
    cpu_sleep = 1'b0;
    wr(4'h4, 8'h10, 8'h00);
  endtask
  // Buffer write lands while the STOP runs and must be dropped
  task automatic t_stop;
    wr(4'h6, 8'h12, 8'h04);
    wr(4'h6, 8'h14, 8'h5a);
    rd(4'h6, 8'h11, 8'ha0);
    wait_irq();
    chk({6'h0, sda_oe_n, scl_oe_n}, 8'h03);
    rd(4'h6, 8'h13, 8'h10, 8'h11);
    rd(4'h6, 8'h12, 8'h00);
    rd(4'h4, 8'h10, 8'h80);
    wr(4'h4, 8'h10, 8'h00);
  endtask
  task automatic t_collision;
    other_scl_low = 1'b1;
    repeat (5) @(negedge ref_clk);
    wr(4'h6, 8'h12, 8'h01);
    wait_irq();
    rd(4'h4, 8'h10, 8'h40, 8'hc0);
    chk({6'h0, sda_oe_n, scl_oe_n}, 8'h03);
    rd(4'h6, 8'h12, 8'h00);
    other_scl_low = 1'b0;
    wr(4'h4, 8'h10, 8'h00);
    // Long count so another master can pull SCL inside each phase
    wr(4'h6, 8'h10, 8'h7f);
    wr(4'h6, 8'h12, 8'h01);
    repeat (20) @(negedge ref_clk);
    other_scl_low = 1'b1;
    wait_irq();
    rd(4'h4, 8'h10, 8'h40, 8'hc0);
    chk({6'h0, sda_oe_n, scl_oe_n}, 8'h03);
    other_scl_low = 1'b0;
    wr(4'h4, 8'h10, 8'h00);
    // SCL pulled low in the second count: no collision, START completes
    wr(4'h6, 8'h12, 8'h01);
    repeat (300) @(negedge ref_clk);
    other_scl_low = 1'b1;
    repeat (5) @(negedge ref_clk);
    other_scl_low = 1'b0;
    wait_irq();
    rd(4'h4, 8'h10, 8'h80, 8'hc0);
    chk({6'h0, sda_oe_n, scl_oe_n}, 8'h00);
    wr(4'h4, 8'h10, 8'h00);
  endtask
  task automatic t_mid_reset;
    wr(4'h6, 8'h12, 8'h01);
    repeat (8) @(negedge ref_clk);
    rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    chk({6'h0, sda_oe_n, scl_oe_n}, 8'h03);
    rd(4'h6, 8'h11, 8'h00);
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, generous against about 650 cycles of work
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    t_reset_values();
    t_start();
    t_stop();
    t_collision();
    t_mid_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
